// ---- psla_pkg.sv ----
// Shared types and constants for the packed logic/compare datapath slice.
// Assumes a single core clock; decode and operand fetch sit on that clock.
package psla_pkg;
  // Datapath geometry
  localparam int unsigned PSLA_W      = 64;
  localparam int unsigned PSLA_NREGS  = 8;
  localparam logic [7:0]  PSLA_ESC    = 8'h0f;
  // Second opcode bytes served here
  localparam logic [7:0]  OP_ADDUSB   = 8'hdc;
  localparam logic [7:0]  OP_ADDUSW   = 8'hdd;
  localparam logic [7:0]  OP_AND      = 8'hdb;
  localparam logic [7:0]  OP_ANDN     = 8'hdf;
  localparam logic [7:0]  OP_CMPEQB   = 8'h74;
  localparam logic [7:0]  OP_CMPEQW   = 8'h75;
  localparam logic [7:0]  OP_CMPEQD   = 8'h76;
  // Saturation limits and fault error code
  localparam logic [7:0]  SAT_B_MAX   = 8'hff;
  localparam logic [7:0]  SAT_B_MIN   = 8'h00;
  localparam logic [15:0] SAT_W_MAX   = 16'hffff;
  localparam logic [15:0] SAT_W_MIN   = 16'h0000;
  localparam logic [31:0] ERR_ZERO    = 32'h0000_0000;
  localparam logic [1:0]  CPL_USER    = 2'h3;
  // Register port map (byte addresses)
  localparam logic [7:0]  REG_CTRL    = 8'h00;
  localparam logic [7:0]  REG_STATUS  = 8'h04;
  localparam logic [7:0]  REG_RES_LO  = 8'h08;
  localparam logic [7:0]  REG_RES_HI  = 8'h0c;
  localparam int unsigned CTRL_EMUL   = 0;
  localparam int unsigned CTRL_TASKSW = 1;
  localparam logic [1:0]  CTRL_RST    = 2'h0;

  typedef enum logic [1:0] {MODE_REAL, MODE_PROT, MODE_V86} psla_mode_t;

  typedef enum logic [3:0] {
    FLT_NONE, FLT_OPCODE, FLT_NODEV, FLT_FPERR, FLT_PROT, FLT_SS, FLT_PAGE, FLT_ALIGN
  } psla_fault_t;

  // One request from decode/operand fetch
  typedef struct packed {
    logic [15:0] opcode;
    logic        src_is_mem;
    logic [2:0]  dst_idx;
    logic [2:0]  src_idx;
    logic [63:0] mem_data;
  } psla_req_t;

  // Address checks done by the memory pipeline for this operand
  typedef struct packed {
    psla_mode_t  mode;
    logic        stack_seg;
    logic        addr_bad;
    logic        page_miss;
    logic [31:0] page_code;
    logic        misaligned;
    logic [1:0]  cpl;
  } psla_memchk_t;
endpackage

// ---- psla_regfile.sv ----
// Packed register file: one write port, two registered read ports.
// Assumes writes and reads are on the same clock; a read in the write
// cycle returns the old word, the caller avoids that by spacing requests.
module psla_regfile
  import psla_pkg::*;
#(
  parameter int unsigned DEPTH = PSLA_NREGS,
  parameter int unsigned WIDTH = PSLA_W
) (
  // Clock
  input  wire logic                     clk,
  // Write port
  input  wire logic                     we,
  input  wire logic [$clog2(DEPTH)-1:0] waddr,
  input  wire logic [WIDTH-1:0]         wdata,
  // Read ports
  input  wire logic [$clog2(DEPTH)-1:0] raddr_a,
  input  wire logic [$clog2(DEPTH)-1:0] raddr_b,
  output logic      [WIDTH-1:0]         rdata_a,
  output logic      [WIDTH-1:0]         rdata_b
);
  logic [WIDTH-1:0] mem [DEPTH];

  if (DEPTH < 2) begin : g_chk
    $error("psla_regfile: DEPTH must be at least 2");
  end

  // Storage, no reset: contents are architectural state
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered reads
  always_ff @(posedge clk) begin
    rdata_a <= mem[raddr_a];
    rdata_b <= mem[raddr_b];
  end
endmodule

// ---- psla_alu.sv ----
// Packed saturating-add, logic and equality-compare slice with fault checks.
// Assumes decode/operand fetch on clk; request taken when req_valid and
// req_ready_q, answer two edges later on done_q.
module psla_alu
  import psla_pkg::*;
#(
  parameter int unsigned NREGS = PSLA_NREGS
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Register port
  input  wire logic [7:0]   reg_addr,
  input  wire logic [31:0]  reg_wdata,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  output logic      [31:0]  reg_rdata_q,
  // Request from decode
  input  wire logic         req_valid,
  input  wire psla_req_t    req,
  input  wire psla_memchk_t mem_chk,
  input  wire logic         fp_pending,
  output logic              req_ready_q,
  // Completion
  output logic              done_q,
  output psla_fault_t       fault_q,
  output logic      [31:0]  fault_code_q,
  output logic      [63:0]  result_q,
  output logic              arith_flags_we_q
);
  if (NREGS != PSLA_NREGS) begin : g_chk
    $error("psla_alu: dest/source index fields serve exactly eight registers");
  end

  logic          rst_s1_q, rst_sync_n;
  logic [1:0]    ctrl_q;
  logic          accept;
  logic          s1_valid_q;
  psla_req_t     s1_req_q;
  psla_fault_t   s1_fault_q, fault_d;
  logic [31:0]   s1_code_q, code_d;
  logic [63:0]   rd_dst, rd_src, src_op, res_d;
  logic          op_ok;
  logic          rf_we;
  logic [63:0]   sum_b, sum_w, eq_b, eq_w, eq_d;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_s1_q   <= 1'b1;
      rst_sync_n <= rst_s1_q;
    end
  end

  // Opcode decode, used at several places
  function automatic logic known_op(input logic [15:0] op);
    logic ok;
    ok = 1'b0;
    if (op[15:8] == PSLA_ESC) begin
      unique case (op[7:0])
        OP_ADDUSB, OP_ADDUSW, OP_AND, OP_ANDN: ok = 1'b1;
        OP_CMPEQB, OP_CMPEQW, OP_CMPEQD:       ok = 1'b1;
        default:                               ok = 1'b0;
      endcase
    end
    return ok;
  endfunction

  // Control register: emulation and task-switched bits
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ctrl_q <= CTRL_RST;
    end else if (reg_wr && reg_addr == REG_CTRL) begin
      ctrl_q <= reg_wdata[1:0];
    end
  end

  // One request in flight; ready drops for the cycle after a take
  assign accept = req_valid && req_ready_q;
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      req_ready_q <= 1'b0;
    end else begin
      req_ready_q <= !accept;
    end
  end

  // Fault priority: control bits, FP pending, then operand checks
  always_comb begin
    fault_d = FLT_NONE;
    code_d  = ERR_ZERO;
    if (ctrl_q[CTRL_EMUL] || !known_op(req.opcode)) begin
      fault_d = FLT_OPCODE;
    end else if (ctrl_q[CTRL_TASKSW]) begin
      fault_d = FLT_NODEV;
    end else if (fp_pending) begin
      fault_d = FLT_FPERR;
    end else if (req.src_is_mem) begin
      if (mem_chk.addr_bad && mem_chk.mode == MODE_PROT && mem_chk.stack_seg) begin
        fault_d = FLT_SS;
      end else if (mem_chk.addr_bad) begin
        fault_d = FLT_PROT;
      end else if (mem_chk.page_miss && mem_chk.mode != MODE_REAL) begin
        fault_d = FLT_PAGE;
        code_d  = mem_chk.page_code;
      end else if (mem_chk.misaligned
                   && (mem_chk.mode == MODE_V86 || mem_chk.cpl == CPL_USER)) begin
        fault_d = FLT_ALIGN;
      end
    end
  end

  // Stage 1 capture; operands arrive from the register file now
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s1_valid_q <= 1'b0;
      s1_req_q   <= '0;
      s1_fault_q <= FLT_NONE;
      s1_code_q  <= ERR_ZERO;
    end else begin
      s1_valid_q <= accept;
      if (accept) begin
        s1_req_q   <= req;
        s1_fault_q <= fault_d;
        s1_code_q  <= code_d;
      end
    end
  end

  psla_regfile #(
    .DEPTH (NREGS),
    .WIDTH (PSLA_W)
  ) u_rf (
    .clk     (clk),
    .we      (rf_we),
    .waddr   (s1_req_q.dst_idx),
    .wdata   (res_d),
    .raddr_a (req.dst_idx),
    .raddr_b (req.src_idx),
    .rdata_a (rd_dst),
    .rdata_b (rd_src)
  );

  // Source operand: register or 64-bit memory word
  assign src_op = s1_req_q.src_is_mem ? s1_req_q.mem_data : rd_src;

  // Lane arithmetic, lanes placed from bit zero upward
  for (genvar i = 0; i < 8; i++) begin : g_byte
    logic [8:0] s;
    assign s = {1'b0, rd_dst[8*i +: 8]} + {1'b0, src_op[8*i +: 8]};
    assign sum_b[8*i +: 8] = s[8] ? SAT_B_MAX : s[7:0];
    assign eq_b[8*i +: 8]  = (rd_dst[8*i +: 8] == src_op[8*i +: 8]) ? 8'hff : 8'h00;
  end
  for (genvar i = 0; i < 4; i++) begin : g_word
    logic [16:0] s;
    assign s = {1'b0, rd_dst[16*i +: 16]} + {1'b0, src_op[16*i +: 16]};
    assign sum_w[16*i +: 16] = s[16] ? SAT_W_MAX : s[15:0];
    assign eq_w[16*i +: 16]  = (rd_dst[16*i +: 16] == src_op[16*i +: 16]) ? 16'hffff
                                                                          : 16'h0000;
  end
  for (genvar i = 0; i < 2; i++) begin : g_dword
    assign eq_d[32*i +: 32] = (rd_dst[32*i +: 32] == src_op[32*i +: 32]) ? 32'hffff_ffff
                                                                          : 32'h0000_0000;
  end

  // Result select by second opcode byte
  always_comb begin
    res_d = rd_dst;
    op_ok = 1'b1;
    unique case (s1_req_q.opcode[7:0])
      OP_ADDUSB: res_d = sum_b;
      OP_ADDUSW: res_d = sum_w;
      OP_AND:    res_d = rd_dst & src_op;
      OP_ANDN:   res_d = ~rd_dst & src_op;
      OP_CMPEQB: res_d = eq_b;
      OP_CMPEQW: res_d = eq_w;
      OP_CMPEQD: res_d = eq_d;
      default:   op_ok = 1'b0;
    endcase
  end

  // Write back only when clean, so a faulting op can restart
  assign rf_we = s1_valid_q && s1_fault_q == FLT_NONE && op_ok;

  // Completion outputs; result shows the old dest word on a fault
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      done_q       <= 1'b0;
      fault_q      <= FLT_NONE;
      fault_code_q <= ERR_ZERO;
      result_q     <= '0;
    end else begin
      done_q <= s1_valid_q;
      if (s1_valid_q) begin
        fault_q      <= s1_fault_q;
        fault_code_q <= s1_code_q;
        result_q     <= rf_we ? res_d : rd_dst;
      end
    end
  end

  // No path exists to the status flags; the strobe is held low
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      arith_flags_we_q <= 1'b0;
    end else begin
      arith_flags_we_q <= 1'b0;
    end
  end

  // Register port reads, data in the following cycle; unmapped reads zero
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      reg_rdata_q <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        REG_CTRL:   reg_rdata_q <= {30'h0, ctrl_q};
        REG_STATUS: reg_rdata_q <= {27'h0, fault_q, done_q};
        REG_RES_LO: reg_rdata_q <= result_q[31:0];
        REG_RES_HI: reg_rdata_q <= result_q[63:32];
        default:    reg_rdata_q <= '0;
      endcase
    end else begin
      reg_rdata_q <= '0;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_n);

  property p_emul_fault;
    accept && ctrl_q[CTRL_EMUL] |-> ##2 done_q && fault_q == FLT_OPCODE;
  endproperty
  a_emul_fault: assert property (p_emul_fault)
    else $error("emulation bit did not fault");

  property p_tasksw_fault;
    accept && !ctrl_q[CTRL_EMUL] && ctrl_q[CTRL_TASKSW] && known_op(req.opcode)
      |-> ##2 fault_q == FLT_NODEV;
  endproperty
  a_tasksw_fault: assert property (p_tasksw_fault)
    else $error("task-switched bit did not fault");

  property p_fp_fault;
    accept && ctrl_q == CTRL_RST && fp_pending && known_op(req.opcode)
      |-> ##2 fault_q == FLT_FPERR;
  endproperty
  a_fp_fault: assert property (p_fp_fault)
    else $error("pending FP error not raised");

  property p_no_wb;
    s1_valid_q && s1_fault_q != FLT_NONE |-> !rf_we ##1 result_q == $past(rd_dst);
  endproperty
  a_no_wb: assert property (p_no_wb)
    else $error("faulting op wrote destination");

  property p_flags;
    !arith_flags_we_q;
  endproperty
  a_flags: assert property (p_flags)
    else $error("status flags strobed");

  property p_andn;
    rf_we && s1_req_q.opcode[7:0] == OP_ANDN |-> ##1 result_q == $past(~rd_dst & src_op);
  endproperty
  a_andn: assert property (p_andn)
    else $error("inverted AND wrong");

  property p_and;
    rf_we && s1_req_q.opcode[7:0] == OP_AND |-> ##1 result_q == $past(rd_dst & src_op);
  endproperty
  a_and: assert property (p_and)
    else $error("AND wrong");

  property p_usb_top;
    rf_we && s1_req_q.opcode[7:0] == OP_ADDUSB
      && ({1'b0, rd_dst[63:56]} + {1'b0, src_op[63:56]}) > 9'h0ff
      |-> ##1 result_q[63:56] == SAT_B_MAX;
  endproperty
  a_usb_top: assert property (p_usb_top)
    else $error("byte saturation missed");

  // Either operand at full scale forces the clamp
  property p_usw;
    rf_we && s1_req_q.opcode[7:0] == OP_ADDUSW
      && (rd_dst[15:0] == SAT_W_MAX || src_op[15:0] == SAT_W_MAX)
      |-> ##1 result_q[15:0] == SAT_W_MAX;
  endproperty
  a_usw: assert property (p_usw)
    else $error("word saturation missed");

  property p_eqd;
    rf_we && s1_req_q.opcode[7:0] == OP_CMPEQD && rd_dst[63:32] != src_op[63:32]
      |-> ##1 result_q[63:32] == 32'h0000_0000;
  endproperty
  a_eqd: assert property (p_eqd)
    else $error("dword compare wrong");

  property p_eqb_lane;
    rf_we && s1_req_q.opcode[7:0] == OP_CMPEQB && rd_dst[15:8] == src_op[15:8]
      |-> ##1 result_q[15:8] == 8'hff;
  endproperty
  a_eqb_lane: assert property (p_eqb_lane)
    else $error("second byte lane compare wrong");

  property p_prot_code;
    done_q && (fault_q == FLT_PROT || fault_q == FLT_SS) |-> fault_code_q == ERR_ZERO;
  endproperty
  a_prot_code: assert property (p_prot_code)
    else $error("nonzero error code");

  property p_stack;
    accept && ctrl_q == CTRL_RST && !fp_pending && known_op(req.opcode) && req.src_is_mem
      && mem_chk.mode == MODE_PROT && mem_chk.stack_seg && mem_chk.addr_bad
      |-> ##2 fault_q == FLT_SS;
  endproperty
  a_stack: assert property (p_stack)
    else $error("stack fault not raised");

  // Code captured at the take must reach the output unchanged
  property p_page_code;
    accept && ctrl_q == CTRL_RST && !fp_pending && known_op(req.opcode) && req.src_is_mem
      && !mem_chk.addr_bad && mem_chk.page_miss && mem_chk.mode == MODE_PROT
      |-> ##2 fault_q == FLT_PAGE && fault_code_q == $past(mem_chk.page_code, 2);
  endproperty
  a_page_code: assert property (p_page_code)
    else $error("page fault or its code wrong");

  property p_align_cpl;
    accept && ctrl_q == CTRL_RST && !fp_pending && known_op(req.opcode) && req.src_is_mem
      && !mem_chk.addr_bad && !mem_chk.page_miss && mem_chk.mode == MODE_PROT
      && mem_chk.cpl != CPL_USER |-> ##2 fault_q == FLT_NONE;
  endproperty
  a_align_cpl: assert property (p_align_cpl)
    else $error("alignment fault below user privilege");
endmodule

// ---- psla_fetch_model.sv ----
// Behavioural decode and operand-fetch model feeding the packed slice.
// Assumes the slice takes a request on an edge where req_ready_q is high.
module psla_fetch_model
  import psla_pkg::*;
(
  // Clock
  input  wire logic    clk,
  // Handshake and operands
  input  wire logic    req_ready_q,
  output logic         req_valid,
  output psla_req_t    req,
  output psla_memchk_t mem_chk,
  output logic         fp_pending
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle at time zero; operand lines carry junk until a request is posted
  initial begin
    req_valid  = 1'b0;
    req        = '1;
    mem_chk    = '1;
    fp_pending = 1'b1;
  end

  // Post one request and hold it until taken, then scramble the lines
  task automatic issue(input psla_req_t r, input psla_memchk_t m, input logic fp);
    int n;
    n = 0;
    req_valid  <= 1'b1;
    req        <= r;
    mem_chk    <= m;
    fp_pending <= fp;
    do begin
      @(posedge clk);
      n++;
    end while (req_ready_q !== 1'b1 && n < 50);
    req_valid  <= 1'b0;
    req        <= ~r;  // Released lines must not look valid
    mem_chk    <= ~m;
    fp_pending <= ~fp;
    @(posedge clk);  // Extra edge keeps valid from toggling twice in one step
  endtask
endmodule

// ---- tb.sv ----
// Self-checking bench for the packed saturating-add, logic and compare slice.
// Assumes psla_pkg, the slice and the fetch model are compiled before it.
`define CHK(g, e, m) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e); end end
module tb import psla_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {psla_fault_t flt; logic [31:0] code; logic [63:0] res;} psla_note_t;

  logic         clk, rst_n, reg_wr, reg_rd, req_valid, fp_pending, req_ready_q;
  logic         done_q, arith_flags_we_q, rd_pend;
  logic [7:0]   reg_addr;
  logic [31:0]  reg_wdata, reg_rdata_q, fault_code_q;
  logic [63:0]  result_q;
  psla_req_t    req;
  psla_memchk_t mem_chk;
  psla_fault_t  fault_q;
  logic [63:0]  regs [8];
  logic [1:0]   ctrl;
  psla_note_t   last;
  psla_note_t   opq [$];
  logic [31:0]  rdq [$];
  logic [7:0]   ops [7] = '{8'hdc, 8'hdd, 8'hdb, 8'hdf, 8'h74, 8'h75, 8'h76};
  int           fail_count, total_checks, cyc;

  psla_alu psla_alu_inst (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .req_valid(req_valid), .req(req), .mem_chk(mem_chk), .fp_pending(fp_pending),
    .req_ready_q(req_ready_q), .done_q(done_q), .fault_q(fault_q),
    .fault_code_q(fault_code_q), .result_q(result_q), .arith_flags_we_q(arith_flags_we_q));

  psla_fetch_model psla_fetch_model_inst (.clk(clk), .req_ready_q(req_ready_q),
    .req_valid(req_valid), .req(req), .mem_chk(mem_chk), .fp_pending(fp_pending));

  // Core clock, 50 ns period
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Lane arithmetic worked out independently of the design
  function automatic logic [63:0] lanes(logic [7:0] op, logic [63:0] d, logic [63:0] s);
    logic [63:0] r, mk, a, b;
    int          w;
    r = '0;
    if (op == 8'hdb) return d & s;
    if (op == 8'hdf) return ~d & s;
    w = (op == 8'hdc || op == 8'h74) ? 8 : (op == 8'hdd || op == 8'h75) ? 16 : 32;
    mk = (64'h1 << w) - 64'h1;
    for (int i = 0; i < 64; i += w) begin
      a = (d >> i) & mk;
      b = (s >> i) & mk;
      if (op == 8'hdc || op == 8'hdd) a = (a + b > mk) ? mk : a + b;
      else a = (a == b) ? mk : 64'h0;
      r = r | (a << i);
    end
    return r;
  endfunction

  // Fault priority as handed over; a faulted op leaves the old value
  function automatic psla_note_t predict(logic [15:0] opc, logic mem, psla_memchk_t m,
                                         logic fp, logic [63:0] d, logic [63:0] s);
    psla_note_t n;
    n.code = '0;
    n.res  = d;
    if (ctrl[0] || opc[15:8] != 8'h0f || !(opc[7:0] inside {ops})) n.flt = FLT_OPCODE;
    else if (ctrl[1]) n.flt = FLT_NODEV;
    else if (fp) n.flt = FLT_FPERR;
    else if (mem && m.mode == MODE_PROT && m.stack_seg && m.addr_bad) n.flt = FLT_SS;
    else if (mem && m.addr_bad) n.flt = FLT_PROT;
    else if (mem && m.page_miss && m.mode != MODE_REAL) begin
      n.flt  = FLT_PAGE;
      n.code = m.page_code;
    end
    else if (mem && m.misaligned && (m.cpl == 2'h3 || m.mode == MODE_V86)) n.flt = FLT_ALIGN;
    else begin
      n.flt = FLT_NONE;
      n.res = lanes(opc[7:0], d, s);
    end
    return n;
  endfunction

  // One operation: note the expectation, then hand it to the fetch model
  task automatic op(logic [7:0] c, int d, int s, logic mem, logic [63:0] md,
                    psla_memchk_t m, logic fp);
    psla_req_t r;
    r.opcode     = {8'h0f, c};
    r.src_is_mem = mem;
    r.dst_idx    = 3'(d);
    r.src_idx    = 3'(s);
    r.mem_data   = md;
    last = predict(r.opcode, mem, m, fp, regs[d], mem ? md : regs[s]);
    regs[d] = last.res;
    opq.push_back(last);
    psla_fetch_model_inst.issue(r, m, fp);
  endtask

  // Register port access; read answers are noted for the monitor
  task automatic bus(logic wr, logic [7:0] a, logic [31:0] wd, logic [31:0] exp);
    reg_wr    <= wr;
    reg_rd    <= !wr;
    reg_addr  <= a;
    reg_wdata <= wd;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    if (!wr) rdq.push_back(exp);
    @(posedge clk);
  endtask

  task automatic results();
    if (fail_count == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Monitor: oldest note against each completion and each read answer
  always @(posedge clk) begin
    psla_note_t  n;
    logic [31:0] e;
    if (done_q === 1'b1) begin
      n = opq.pop_front();
      `CHK(fault_q, n.flt, "fault")
      `CHK(fault_code_q, n.code, "code")
      `CHK(result_q[31:0], n.res[31:0], "res_lo")
      `CHK(result_q[63:32], n.res[63:32], "res_hi")
      `CHK(arith_flags_we_q, 1'b0, "flags")
    end
    if (rd_pend) begin
      e = rdq.pop_front();
      `CHK(reg_rdata_q, e, "read")
    end
    rd_pend = (reg_rd === 1'b1);
  end

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      results();
    end
  end

  // Main sequence
  initial begin
    psla_memchk_t ok_m, m;
    logic [63:0]  v;
    logic [7:0]   c;
    logic         fp, mem;
    int           d, s, sel;
    void'($urandom(32'h4a56));
    {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, ctrl, rd_pend} = '0;
    {cyc, fail_count, total_checks} = '0;
    ok_m = '0;
    ok_m.mode = MODE_PROT;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    bus(0, 8'h00, 32'h0, 32'h0);
    bus(0, 8'h10, 32'h0, 32'h0);
    // No load port: clear with AND of zero, then load through inverted AND
    for (int i = 0; i < 8; i++) begin
      op(8'hdb, i, i, 1'b1, 64'h0, ok_m, 1'b0);
      op(8'hdf, i, i, 1'b1, {$urandom, $urandom}, ok_m, 1'b0);
    end
    // Random ops, biased toward saturation and equal lanes
    for (int k = 0; k < 80; k++) begin
      d   = $urandom % 8;
      s   = $urandom % 8;
      sel = $urandom % 4;
      v   = {$urandom, $urandom};
      if (sel == 1) v = regs[d];
      if (sel == 2) v = '1;
      if (sel == 3) v = regs[d] ^ (v & 64'hff00_0000_ffff_0000);
      op(ops[$urandom % 7], d, s, sel != 0 || $urandom % 2, v, ok_m, 1'b0);
    end
    // Fault and no-fault boundary cases, each followed by a status and control read-back
    for (int k = 0; k < 14; k++) begin
      m    = ok_m;
      fp   = 1'b0;
      mem  = 1'b1;
      ctrl = 2'h0;
      c    = ops[k % 7];
      case (k)
        0: ctrl = 2'h1;
        1: ctrl = 2'h2;
        2: ctrl = 2'h3;
        3: fp = 1'b1;
        4: {m.stack_seg, m.addr_bad} = 2'h3;
        5: m.addr_bad = 1'b1;
        6: begin
          m.mode     = MODE_REAL;
          m.addr_bad = 1'b1;
        end
        7: {m.page_miss, m.page_code} = {1'b1, 32'($urandom)};
        8: begin
          m.mode      = MODE_REAL;
          m.page_miss = 1'b1;
        end
        9: {m.misaligned, m.cpl} = {1'b1, 2'h3};
        10: m.misaligned = 1'b1;
        11: begin
          m.mode       = MODE_V86;
          m.misaligned = 1'b1;
        end
        12: c = 8'h00;
        default: {mem, m.addr_bad, m.page_miss} = 3'h3;
      endcase
      bus(1, 8'h00, {30'h0, ctrl}, 32'h0);
      op(c, $urandom % 8, $urandom % 8, mem, {$urandom, $urandom}, m, fp);
      repeat (2) @(posedge clk);
      bus(0, 8'h04, 32'h0, {27'h0, last.flt, 1'b0});
      bus(0, 8'h00, 32'h0, {30'h0, ctrl});
    end
    ctrl = 2'h0;
    bus(1, 8'h00, 32'h0, 32'h0);
    bus(1, 8'h04, 32'hffff_ffff, 32'h0);
    bus(0, 8'h04, 32'h0, {27'h0, last.flt, 1'b0});
    bus(0, 8'h08, 32'h0, last.res[31:0]);
    bus(0, 8'h0c, 32'h0, last.res[63:32]);
    repeat (4) @(posedge clk);
    `CHK(opq.size() + rdq.size(), 0, "pending")
    results();
  end
endmodule
